// ### hw/epi_pkg.sv
// Package: constants, register map and carrier types of the external pin interrupt unit
// Overview of operation
// - Two sense bits pick level, change, falling, rising
// - Level mode requests while pin stays low
// - Pin value detected even when driven out
// - Request needs global enable and line enable
// - Sample pins, compare samples, catch wide pulses
// - Edge detection needs running I/O clock
// - Edge or change event sets pending flag
// - Flag cleared by vector entry or one-write
// - Level-mode line keeps its flag at zero
// - Wake needs two watchdog samples of level
// - Vanished level wakes but raises no interrupt
// - Enables bits 3..0, sense two bits per line
package epi_pkg;

   // Geometry
   localparam int NUM_LINES = 4;
   localparam int ADR_W     = 4;
   localparam int DAT_W     = 32;

   // Register byte offsets
   localparam logic [ADR_W-1:0] OFS_SENSE   = 4'h0;
   localparam logic [ADR_W-1:0] OFS_ENABLE  = 4'h4;
   localparam logic [ADR_W-1:0] OFS_PENDING = 4'h8;

   // Reset values
   localparam logic [7:0] RST_SENSE   = 8'h00;
   localparam logic [7:0] RST_ENABLE  = 8'h00;
   localparam logic [3:0] RST_PENDING = 4'h0;

   // Field layout: line n sense at bits 2n+1:2n, enable at bit n
   localparam int SENSE_W = 2;

   // Sense codes {sense_select_hi, sense_select_lo}
   localparam logic [1:0] SENSE_LOW    = 2'h0;
   localparam logic [1:0] SENSE_CHANGE = 2'h1;
   localparam logic [1:0] SENSE_FALL   = 2'h2;
   localparam logic [1:0] SENSE_RISE   = 2'h3;

   // Timing: start-up delay after a wake-up
   localparam int CLK_PERIOD_NS   = 50;
   localparam int STARTUP_TIME_NS = 4000;
   localparam int STARTUP_CYCLES  =
      (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Wishbone request from the master
   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [3:0]       sel;
      logic [DAT_W-1:0] dat;
   } epi_wb_req_t;

   // Wishbone answer to the master
   typedef struct packed {
      logic             ack;
      logic [DAT_W-1:0] dat;
   } epi_wb_rsp_t;

   // Wake sequencer states
   typedef enum logic [2:0] {
      WK_IDLE    = 3'b001,
      WK_SAMPLE  = 3'b010,
      WK_STARTUP = 3'b100
   } epi_wake_state_t;

endpackage

// ### hw/epi_line.sv
// One pin line: sampling and edge/change/level detection
module epi_line
   import epi_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // Pin and configuration
   input  wire logic       pinVal,
   input  wire logic [1:0] sense,
   input  wire logic       ioClkRun,
   // Detection results
   output logic            edgeEvent,
   output logic            levelLow
);

   logic prevSample;    // Previous pin sample
   logic next_prevSample;
   logic changed;       // Samples differ
   logic fell;          // High then low
   logic rose;          // Low then high

   // Sample only while the I/O clock runs, so edges in deep sleep go unseen
   assign next_prevSample = ioClkRun ? pinVal : prevSample;

   // Successive samples compared; one full cycle wide pulse is caught while the I/O clock runs
   assign changed = ioClkRun & (pinVal ^ prevSample);
   assign fell    = changed & prevSample;
   assign rose    = changed & pinVal;

   // Sense decode; the pad value is used whatever the pin direction
   assign edgeEvent = (sense == SENSE_CHANGE) ? changed :
                      (sense == SENSE_FALL)   ? fell :
                      (sense == SENSE_RISE)   ? rose : 1'b0;
   assign levelLow  = (sense == SENSE_LOW) & ~pinVal;

   // Sample register; reset to high so no edge is invented after reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         prevSample <= 1'b1;
      end else begin
         prevSample <= next_prevSample;
      end
   end

endmodule

// ### hw/epi_wake.sv
// Power-down wake-up: double watchdog sampling and start-up delay
module epi_wake
   import epi_pkg::*;
#(
   parameter int STARTUP = STARTUP_CYCLES
)
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Wake conditions
   input  wire logic powerDown,
   input  wire logic wdtTick,
   input  wire logic wakeLevel,
   // Results
   output logic      wakeUp,
   output logic      startupBusy
);

   epi_wake_state_t state;       // Current state
   epi_wake_state_t next_state;
   logic [15:0]     startCnt;    // Start-up countdown
   logic [15:0]     next_startCnt;

   // Second watchdog sample confirms the level
   // Power-down must still hold, or a late tick would wake a running device
   assign wakeUp      = (state == WK_SAMPLE) & powerDown & wdtTick & wakeLevel;
   assign startupBusy = (state == WK_STARTUP);

   // Next state
   always_comb begin
      next_state    = state;
      next_startCnt = startCnt;
      case (state)
         WK_IDLE: begin
            // First sample of the level
            if (powerDown & wdtTick & wakeLevel) begin
               next_state = WK_SAMPLE;
            end
         end
         WK_SAMPLE: begin
            if (wakeUp) begin
               next_state    = WK_STARTUP;
               next_startCnt = 16'(STARTUP - 1);
            end else if (wdtTick | ~powerDown) begin
               next_state = WK_IDLE;
            end
         end
         WK_STARTUP: begin
            // Level requests wait; a level gone by the end raises nothing
            if (startCnt == 16'h0000) begin
               next_state = WK_IDLE;
            end else begin
               next_startCnt = startCnt - 16'h0001;
            end
         end
         default: begin
            next_state = WK_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state    <= WK_IDLE;
         startCnt <= 16'h0000;
      end else begin
         state    <= next_state;
         startCnt <= next_startCnt;
      end
   end

endmodule

// ### hw/epi_ctrl.sv
// Top: external pin interrupt unit with Wishbone registers
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
module epi_ctrl
   import epi_pkg::*;
#(
   parameter int LINES   = NUM_LINES,
   parameter int STARTUP = STARTUP_CYCLES
)
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // Register bus
   input  epi_pkg::epi_wb_req_t   wbReq,
   output epi_pkg::epi_wb_rsp_t   wbRsp,
   // Pins
   input  wire logic [LINES-1:0]  ext_irq_pins,
   // Processor side
   input  wire logic              globalIrqEnable,
   input  wire logic [LINES-1:0]  irqAck,
   output logic      [LINES-1:0]  irqReq,
   output logic                   irqOut,
   // Power management
   input  wire logic              ioClkRun,
   input  wire logic              powerDown,
   input  wire logic              wdtTick,
   output logic                   wakeUp
);
   import epi_pkg::*;

   // Registers seen by software
   logic [7:0]       pin_irq_sense_control;  // Two sense bits per line
   logic [7:0]       pin_irq_enable_mask;    // Line enables in low bits
   logic [LINES-1:0] line_pending_flag;      // Sticky event flags

   // Next values
   logic [7:0]       next_sense;
   logic [7:0]       next_enable;
   logic [LINES-1:0] next_pending;

   // Bus slave state
   logic             ack;                    // Registered acknowledge
   logic [DAT_W-1:0] rdData;                 // Registered read data
   logic [DAT_W-1:0] next_rdData;

   // Decode wires
   logic             busReq;                 // Active bus cycle
   logic             wrCommit;               // Write takes effect now
   logic             lowLane;                // Byte lane 0 enabled
   logic             selSense;
   logic             selEnable;
   logic             selPending;
   logic [7:0]       wrByte;                 // Low write byte

   // Per-line detection
   logic [LINES-1:0] edgeEvent;              // Edge or change seen
   logic [LINES-1:0] levelLow;               // Level mode and pin low
   logic [LINES-1:0] levelMode;              // Line in level sense
   logic [LINES-1:0] lineEnable;             // Enable bits of lines
   logic [LINES-1:0] flagClear;              // Clears from bus or ack
   logic [LINES-1:0] lineReq;                // Enabled request per line

   // Wake path
   logic             wakeLevel;              // Any enabled level line low
   logic             startupBusy;            // Start-up delay running

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------

   // A request is live while cyc and stb are both high
   assign busReq   = wbReq.cyc & wbReq.stb;

   // Writes land on the edge where the master sees ack high
   assign wrCommit = busReq & wbReq.we & ack;

   // Registers are one byte wide and sit in lane 0
   assign lowLane  = wbReq.sel[0];
   assign wrByte   = wbReq.dat[7:0];

   // Address compare on the full byte offset
   assign selSense   = (wbReq.adr == OFS_SENSE);
   assign selEnable  = (wbReq.adr == OFS_ENABLE);
   assign selPending = (wbReq.adr == OFS_PENDING);

   // Read mux; unmapped words and upper bits read as zero
   assign next_rdData =
      selSense   ? {24'h000000, pin_irq_sense_control} :
      selEnable  ? {24'h000000, pin_irq_enable_mask} :
      selPending ? {{(DAT_W-LINES){1'b0}}, line_pending_flag} :
                   {DAT_W{1'b0}};

   // Answer
   assign wbRsp.ack = ack;
   assign wbRsp.dat = rdData;

   // ------------------------------------------------------------------
   // Control register writes
   // ------------------------------------------------------------------

   // Sense field; software is expected to disable a line before changing it
   assign next_sense = (wrCommit & selSense & lowLane) ?
                       wrByte : pin_irq_sense_control;

   // Enable mask; all eight bits stored, low four gate the lines
   assign next_enable = (wrCommit & selEnable & lowLane) ?
                        wrByte : pin_irq_enable_mask;

   // ------------------------------------------------------------------
   // Line detectors
   // ------------------------------------------------------------------

   // One detector per line, fed its own two-bit sense field
   generate
      for (genvar n = 0; n < LINES; n++) begin : g_line
         // Field of line n sits at bits 2n+1:2n
         epi_line u_line (
            .mclk      (mclk),
            .sys_rst   (sys_rst),
            .pinVal    (ext_irq_pins[n]),
            .sense     (pin_irq_sense_control[SENSE_W*n +: SENSE_W]),
            .ioClkRun  (ioClkRun),
            .edgeEvent (edgeEvent[n]),
            .levelLow  (levelLow[n])
         );
         // Level mode decode for the pending flag path
         assign levelMode[n] =
            (pin_irq_sense_control[SENSE_W*n +: SENSE_W] == SENSE_LOW);
      end
   endgenerate

   // Enables: line n at bit n
   assign lineEnable = pin_irq_enable_mask[LINES-1:0];

   // ------------------------------------------------------------------
   // Pending flags
   // ------------------------------------------------------------------

   // Clears: one written to the bit, or the vector taken for that line
   assign flagClear =
      ((wrCommit & selPending & lowLane) ? wrByte[LINES-1:0] : '0)
      | irqAck;

   // Level lines hold zero; otherwise an event beats a same-cycle clear
   assign next_pending = ~levelMode &
                         (edgeEvent | (line_pending_flag & ~flagClear));

   // ------------------------------------------------------------------
   // Requests to the processor
   // ------------------------------------------------------------------

   // Flag in edge modes, live low level in level mode, gated by enable.
   // Level requests are held back during the start-up after a wake.
   assign lineReq = lineEnable &
                    ((levelLow & {LINES{~startupBusy}})
                     | line_pending_flag);

   // The core takes a line only with its global flag set too
   assign irqReq = lineReq & {LINES{globalIrqEnable}};

   // Summary level output, high while any enabled source is active
   assign irqOut = |lineReq;

   // ------------------------------------------------------------------
   // Wake-up from power-down
   // ------------------------------------------------------------------

   // Only enabled level lines may wake the device; edges need the I/O clock
   assign wakeLevel = |(lineEnable & levelLow);

   // Double sampling on watchdog ticks, then the start-up delay
   epi_wake #(
      .STARTUP (STARTUP)
   ) u_wake (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .powerDown   (powerDown),
      .wdtTick     (wdtTick),
      .wakeLevel   (wakeLevel),
      .wakeUp      (wakeUp),
      .startupBusy (startupBusy)
   );

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------

   // Bus slave: ack one cycle after the request, dropped the next cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack    <= 1'b0;
         rdData <= '0;
      end else begin
         ack    <= busReq & ~ack;
         rdData <= next_rdData;
      end
   end

   // Software-visible state; all zero after reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_irq_sense_control <= RST_SENSE;
         pin_irq_enable_mask   <= RST_ENABLE;
         line_pending_flag     <= RST_PENDING;
      end else begin
         pin_irq_sense_control <= next_sense;
         pin_irq_enable_mask   <= next_enable;
         line_pending_flag     <= next_pending;
      end
   end

endmodule

// ### verification/epi_ctrl_chk.sv
// Checker: port assertions of the pin interrupt unit, watching line 0
module epi_ctrl_chk
   import epi_pkg::*;
#(
   parameter int LINES   = NUM_LINES,
   parameter int STARTUP = STARTUP_CYCLES
)
(
   // Clock, reset and bus
   input wire logic             mclk,
   input wire logic             sys_rst,
   input epi_pkg::epi_wb_req_t  wbReq,
   input epi_pkg::epi_wb_rsp_t  wbRsp,
   // Pins and core
   input wire logic [LINES-1:0] ext_irq_pins,
   input wire logic             globalIrqEnable,
   input wire logic [LINES-1:0] irqAck,
   input wire logic [LINES-1:0] irqReq,
   input wire logic             irqOut,
   // Power
   input wire logic             ioClkRun,
   input wire logic             powerDown,
   input wire logic             wdtTick,
   input wire logic             wakeUp
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic [1:0] sense0; // Shadow of the line 0 sense field
   logic       en0;    // Shadow of the line 0 enable
   int         stCnt;  // One spare cycle, so start-up masking is never judged early
   wire        wrOk  = wbReq.we && wbRsp.ack && wbReq.sel[0];
   wire        idle0 = stCnt == 0 && !wakeUp;
   // Shadows follow writes at the ack edge
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sense0 <= 2'h0;
         en0 <= 1'b0;
         stCnt <= 0;
      end else begin
         if (wrOk && wbReq.adr == OFS_SENSE) sense0 <= wbReq.dat[1:0];
         if (wrOk && wbReq.adr == OFS_ENABLE) en0 <= wbReq.dat[0];
         stCnt <= wakeUp ? STARTUP + 1 : (stCnt != 0 ? stCnt - 1 : 0);
      end
   end
   ack_once_a: assert property (wbRsp.ack |=> !wbRsp.ack)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
      else $error("no ack one cycle after request");
   read_upper_a: assert property (wbRsp.ack && !wbReq.we |-> wbRsp.dat[31:8] == 24'h0)
      else $error("upper read bits not zero");
   global_gate_a: assert property (!globalIrqEnable |-> irqReq == '0)
      else $error("request without global enable");
   irq_out_a: assert property (globalIrqEnable |-> irqOut == (|irqReq))
      else $error("interrupt output differs from requests");
   level_req_a: assert property (sense0 == SENSE_LOW && en0 && !ext_irq_pins[0]
      && globalIrqEnable && idle0 |-> irqReq[0]) else $error("low level gives no request");
   edge_set_a: assert property (en0 && ioClkRun && $past(ioClkRun) && (
      (sense0 == SENSE_RISE && $rose(ext_irq_pins[0])) ||
      (sense0 == SENSE_FALL && $fell(ext_irq_pins[0])) ||
      (sense0 == SENSE_CHANGE && $changed(ext_irq_pins[0])))
      |=> irqReq[0] || !globalIrqEnable) else $error("edge did not set flag");
   ack_clear_a: assert property (irqAck[0] && ext_irq_pins[0] && $stable(ext_irq_pins[0])
      && ioClkRun && $past(ioClkRun) |=> !irqReq[0]) else $error("ack left flag set");
   wake_pulse_a: assert property (wakeUp |-> powerDown ##1 !wakeUp)
      else $error("bad wake pulse");
   cover property (wakeUp);
   cover property (irqAck[0] && irqReq[0]);
   cover property (sense0 == SENSE_LOW && irqReq[0]);
endmodule

bind epi_ctrl epi_ctrl_chk #(.LINES(LINES), .STARTUP(STARTUP)) chk (.mclk(mclk),
   .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp), .ext_irq_pins(ext_irq_pins),
   .globalIrqEnable(globalIrqEnable), .irqAck(irqAck), .irqReq(irqReq), .irqOut(irqOut),
   .ioClkRun(ioClkRun), .powerDown(powerDown), .wdtTick(wdtTick), .wakeUp(wakeUp));

// ### verification/epi_pin_src.sv
// Partner: external sources driving the four interrupt pins
module epi_pin_src
   import epi_pkg::*;
(
   // Clock and requested levels
   input  wire logic                 mclk,
   input  wire logic [NUM_LINES-1:0] want,
   input  wire logic                 slow,
   // Pin levels
   output logic      [NUM_LINES-1:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [NUM_LINES-1:0] dly = '1; // Lag stage of a slow source
   initial pins = '1;
   // Levels change only at edges, so a low is held whole cycles until released
   always @(posedge mclk) begin
      dly <= want;
      pins <= slow ? dly : want;
   end
endmodule

// ### verification/test_epi_ctrl.sv
// Testbench: random and corner tests of the pin interrupt unit
module test_epi_ctrl
   import epi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int ST = 4; // Short start-up keeps the run brief
   logic        mclk = 0, sys_rst = 1, gie = 0, ioRun = 1, pd = 0, tick = 0, slow = 0;
   logic [3:0]  want = 4'hf, ack = 4'h0, pins, req;
   logic        irqOut, wake, v, e, lvl;
   logic [7:0]  r;
   logic [31:0] q;
   epi_wb_req_t wbReq = '0;
   epi_wb_rsp_t wbRsp;
   int          errors = 0, checked = 0, cyc = 0, wakes = 0;
   epi_pin_src src (.mclk(mclk), .want(want), .slow(slow), .pins(pins));
   epi_ctrl #(.STARTUP(ST)) DUT (.mclk(mclk), .sys_rst(sys_rst), .wbReq(wbReq),
      .wbRsp(wbRsp), .ext_irq_pins(pins), .globalIrqEnable(gie), .irqAck(ack), .irqReq(req),
      .irqOut(irqOut), .ioClkRun(ioRun), .powerDown(pd), .wdtTick(tick), .wakeUp(wake));
   initial forever #25 mclk = ~mclk;
   // Cycle limit and wake pulse count
   always @(posedge mclk) begin
      cyc++;
      wakes += int'(wake === 1'b1);
      if (cyc > 30000) begin
         errors++;
         wrap_up;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // One classic cycle, held until ack is sampled
   // Only the cycle limit ends a wait for ack
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      wbReq <= '{1'b1, 1'b1, we, a, 4'hf, d};
      do begin
         @(posedge mclk);
      end while (wbRsp.ack !== 1'b1);
      q = wbRsp.dat;
      wbReq <= '0;
   endtask
   task automatic tk;
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic wrap_up;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic evt(logic [1:0] m, logic o, logic n);
      return (m == SENSE_CHANGE && o != n) || (m == SENSE_FALL && o && !n) ||
         (m == SENSE_RISE && !o && n);
   endfunction
   initial begin
      r = 8'($urandom(40));
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      // Reset values, unmapped word included
      for (int a = 0; a < 16; a += 4) begin
         wb(1'b0, 4'(a), 32'h0);
         chk(q, 32'h0);
      end
      r = 8'($urandom);
      wb(1'b1, OFS_SENSE, {24'h0, r});
      wb(1'b0, OFS_SENSE, 32'h0);
      chk(q, {24'h0, r});
      $display("test registers done");
      // Every sense code on every line, random source speed and global enable
      for (int n = 0; n < 4; n++) begin
         for (int m = 0; m < 4; m++) begin
            wb(1'b1, OFS_ENABLE, 32'h0);
            wb(1'b1, OFS_SENSE, 32'(m << (2 * n)));
            wb(1'b1, OFS_PENDING, 32'hf);
            wb(1'b1, OFS_ENABLE, 32'(1 << n));
            lvl = (m == 0);
            for (int s = 0; s < 4; s++) begin
               v = s[0];
               e = evt(2'(m), !v, v);
               slow <= 1'($urandom);
               gie <= 1'($urandom);
               want[n] <= v;
               repeat (4) @(posedge mclk);
               chk(req[n], lvl ? !v & gie : e & gie);
               chk(irqOut, lvl ? !v : e);
               wb(1'b0, OFS_PENDING, 32'h0);
               chk(q, 32'(e) << n);
               if (s[1]) begin
                  ack[n] <= 1'b1;
                  @(posedge mclk);
                  ack <= 4'h0;
               end else wb(1'b1, OFS_PENDING, 32'(1 << n));
               repeat (2) @(posedge mclk);
               chk(irqOut, lvl & !v);
            end
         end
      end
      $display("test sense modes done");
      // A wide low pulse while the I/O clock is stopped goes unseen
      wb(1'b1, OFS_ENABLE, 32'h0);
      wb(1'b1, OFS_SENSE, 32'(SENSE_FALL));
      wb(1'b1, OFS_PENDING, 32'hf);
      wb(1'b1, OFS_ENABLE, 32'h1);
      ioRun <= 1'b0;
      want[0] <= 1'b0;
      repeat (3) @(posedge mclk);
      want[0] <= 1'b1;
      repeat (3) @(posedge mclk);
      ioRun <= 1'b1;
      wb(1'b0, OFS_PENDING, 32'h0);
      chk(q, 32'h0);
      $display("test clock stop done");
      // Power-down wake: one low sample is not enough, two are
      wb(1'b1, OFS_ENABLE, 32'h0);
      wb(1'b1, OFS_SENSE, 32'h0);
      wb(1'b1, OFS_ENABLE, 32'h1);
      gie <= 1'b1;
      pd <= 1'b1;
      // Pin settles low before the first tick, high before the second
      want[0] <= 1'b0;
      repeat (3) @(posedge mclk);
      tk;
      want[0] <= 1'b1;
      repeat (3) @(posedge mclk);
      tk;
      chk(wakes, 0);
      want[0] <= 1'b0;
      repeat (3) @(posedge mclk);
      tk;
      tk;
      chk(wakes, 1);
      chk(req[0], 1'b0);
      want[0] <= 1'b1;
      repeat (ST + 3) @(posedge mclk);
      chk(req[0], 1'b0);
      // Level held through the start-up gives the request afterwards
      want[0] <= 1'b0;
      repeat (3) @(posedge mclk);
      tk;
      tk;
      chk(wakes, 2);
      chk(req[0], 1'b0);
      repeat (ST + 2) @(posedge mclk);
      chk(req[0], 1'b1);
      want[0] <= 1'b1;
      pd <= 1'b0;
      $display("test wake done");
      wrap_up;
   end
endmodule
